// File: inc/cosc_cfg.svh
// Constants for the crystal oscillator status and control block.
// Assumes an APB slave with byte addresses and 32-bit aligned registers.
// Notes on behaviour
// - Status bit 31 is a read-only stable flag that resets to 0 and is 1 only while the oscillator runs and is usable.
// - Status bit 24 is set sticky by an illegal enable, range or pause code, and any write to status clears it.
// - Status bit 12 reads 1 while the oscillator is enabled and not paused, whether stable or not, and 0 after reset.
// - Status bits 1:0 always read zero, the code for the 1 to 15 MHz range.
// - The 32-bit pause register stops the oscillator on the pause code and selects running on the wake code.
// - The pause register powers up as wake, and any other written value also selects wake.
// - Start-up delay bits 13:0 give the wait after enable in units of 256 crystal periods.
// - Start-up bit 20 makes the programmed wait four times longer.
// - The 8-bit counter at bits 7:0 drops by one per crystal cycle, stops at zero and resets to zero.
// - Writing a non-zero value starts the counter, and software polls it until it reads zero.
// - Leaving the paused state restarts the oscillator and runs the whole start-up wait before stable.
// - The 12-bit enable field disables on 0xd1e, enables on 0xfab or any other code, and powers up disabled.
// - The stable flag is set when the start-up wait expires after enable.
// - The 12-bit range field always holds 0xAA0 whatever is written.
`ifndef COSC_CFG_SVH
`define COSC_CFG_SVH

// ==================================================================
// Register byte offsets.
`define COSC_OFS_CTRL 8'h00
`define COSC_OFS_STATE 8'h04
`define COSC_OFS_PAUSE 8'h08
`define COSC_OFS_SETTLE 8'h0C
`define COSC_OFS_COUNT 8'h1C
`define COSC_OFS_IRQ_STAT 8'h20
`define COSC_OFS_IRQ_MASK 8'h24

// ==================================================================
// Field positions.
`define COSC_BIT_STABLE 31
`define COSC_BIT_ILLEGAL 24
`define COSC_BIT_ENABLED 12
`define COSC_EN_MSB 23
`define COSC_EN_LSB 12
`define COSC_RNG_MSB 11
`define COSC_RNG_LSB 0
`define COSC_RNG_RD_MSB 1
`define COSC_RNG_RD_LSB 0
`define COSC_BIT_TIMES4 20
`define COSC_UNIT_SHIFT 8
`define COSC_X4_SHIFT 2
`define COSC_IRQ_W 3
`define COSC_IRQ_STABLE 0
`define COSC_IRQ_CNT_ZERO 1
`define COSC_IRQ_ILLEGAL 2

// ==================================================================
// Codes and reset values.
`define COSC_EN_DISABLE 12'hD1E
`define COSC_EN_ENABLE 12'hFAB
`define COSC_RNG_FIXED 12'hAA0
`define COSC_RNG_LAST 12'hAA3
`define COSC_RANGE_READ 2'h0
`define COSC_PAUSE_STOP 32'h636F6D61
`define COSC_PAUSE_WAKE 32'h77616B65

`endif

// File: inc/cosc_pkg.sv
// Types for the crystal oscillator status and control block.
// Assumes cosc_cfg.svh supplies the numeric constants.
package cosc_pkg;

  // ==================================================================
  // Start-up sequencing states.
  typedef enum logic [1:0] {
    COSC_OFF,
    COSC_WAITING,
    COSC_STABLE
  } cosc_state_t;

  typedef logic [31:0] cosc_word_t;

endpackage : cosc_pkg

// File: design/cosc_top.sv
// APB register block with start-up timer and down counter for a crystal oscillator.
// Assumes the crystal clock arrives as a pin slower than half of i_clk.
`timescale 1ns/10ps
`default_nettype none
`include "cosc_cfg.svh"

module cosc_top
  import cosc_pkg::*;
#(
  parameter int DELAY_W = 14,
  parameter int COUNT_W = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Oscillator side.
  input wire logic i_xtal_clk,
  output logic o_osc_run,
  output logic o_osc_stable,
  // Interrupt.
  output logic o_irq
);

  localparam int TGT_W = DELAY_W + `COSC_UNIT_SHIFT + `COSC_X4_SHIFT;

  // Refuses widths that overlap the times-four bit or exceed the data bus.
  if (DELAY_W < 1 || DELAY_W > 20 || COUNT_W < 1 || COUNT_W > 32) begin : g_bad_params
    $error("cosc_top: unsupported DELAY_W or COUNT_W");
  end

  // ==================================================================
  // Bus handshake.
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic access_go;
  logic wr_commit;
  logic rd_commit;
  logic mapped;
  cosc_word_t rdata;

  assign access_go = i_psel && i_penable && !pready_r;
  assign wr_commit = i_psel && i_penable && pready_r && i_pwrite;
  assign rd_commit = i_psel && i_penable && pready_r && !i_pwrite;

  // ==================================================================
  // Register state.
  logic [11:0] en_code_r;
  cosc_word_t pause_r;
  logic [DELAY_W-1:0] delay_r;
  logic times4_r;
  logic [COUNT_W-1:0] count_r;
  logic illegal_r;
  logic [`COSC_IRQ_W-1:0] irq_stat_r;
  logic [`COSC_IRQ_W-1:0] irq_mask_r;
  logic irq_r;
  cosc_state_t state_r;
  logic [TGT_W-1:0] wait_r;
  logic stable_r;
  logic run_r;
  logic count_zero_evt;

  // ==================================================================
  // Crystal clock synchroniser and edge detect.
  logic xtal_s1_r;
  logic xtal_s2_r;
  logic xtal_s3_r;
  logic xtal_edge;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xtal_s1_r <= 1'b0;
      xtal_s2_r <= 1'b0;
      xtal_s3_r <= 1'b0;
    end else begin
      xtal_s1_r <= i_xtal_clk;
      xtal_s2_r <= xtal_s1_r;
      xtal_s3_r <= xtal_s2_r;
    end
  end

  assign xtal_edge = xtal_s2_r && !xtal_s3_r;

  // ==================================================================
  // Write decode helpers.
  // All inputs are arguments, so continuous assignments see every change.
  function automatic logic is_wr(input logic commit, input logic [7:0] addr, input logic [7:0] ofs);
    is_wr = commit && (addr == ofs);
  endfunction : is_wr

  logic en_bad;
  logic rng_bad;
  logic pause_bad;
  logic [11:0] wr_en;
  logic [11:0] wr_rng;

  assign wr_en = i_pwdata[`COSC_EN_MSB:`COSC_EN_LSB];
  assign wr_rng = i_pwdata[`COSC_RNG_MSB:`COSC_RNG_LSB];
  assign en_bad = (wr_en != `COSC_EN_DISABLE) && (wr_en != `COSC_EN_ENABLE);
  assign rng_bad = (wr_rng < `COSC_RNG_FIXED) || (wr_rng > `COSC_RNG_LAST);
  assign pause_bad = (i_pwdata != `COSC_PAUSE_STOP) && (i_pwdata != `COSC_PAUSE_WAKE);

  logic illegal_evt;
  assign illegal_evt = (is_wr(wr_commit, i_paddr, `COSC_OFS_CTRL) && (en_bad || rng_bad)) ||
    (is_wr(wr_commit, i_paddr, `COSC_OFS_PAUSE) && pause_bad);

  // ==================================================================
  // Control registers.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_code_r <= `COSC_EN_DISABLE;
    end else if (is_wr(wr_commit, i_paddr, `COSC_OFS_CTRL)) begin
      en_code_r <= wr_en;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pause_r <= `COSC_PAUSE_WAKE;
    end else if (is_wr(wr_commit, i_paddr, `COSC_OFS_PAUSE)) begin
      pause_r <= (i_pwdata == `COSC_PAUSE_STOP) ? `COSC_PAUSE_STOP : `COSC_PAUSE_WAKE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      delay_r <= '0;
      times4_r <= 1'b0;
    end else if (is_wr(wr_commit, i_paddr, `COSC_OFS_SETTLE)) begin
      delay_r <= i_pwdata[DELAY_W-1:0];
      times4_r <= i_pwdata[`COSC_BIT_TIMES4];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      illegal_r <= 1'b0;
    end else if (illegal_evt) begin
      illegal_r <= 1'b1;
    end else if (is_wr(wr_commit, i_paddr, `COSC_OFS_STATE)) begin
      illegal_r <= 1'b0;
    end
  end

  // ==================================================================
  // Short delay down counter.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= '0;
    end else if (is_wr(wr_commit, i_paddr, `COSC_OFS_COUNT)) begin
      count_r <= i_pwdata[COUNT_W-1:0];
    end else if (xtal_edge && (count_r != '0)) begin
      count_r <= count_r - COUNT_W'(1);
    end
  end

  assign count_zero_evt = xtal_edge && (count_r == COUNT_W'(1)) && !is_wr(wr_commit, i_paddr, `COSC_OFS_COUNT);

  // ==================================================================
  // Start-up sequencing.
  logic run;
  logic [TGT_W-1:0] target;

  assign run = (en_code_r != `COSC_EN_DISABLE) && (pause_r != `COSC_PAUSE_STOP);
  assign target = TGT_W'({delay_r, `COSC_UNIT_SHIFT'(0)}) << (times4_r ? `COSC_X4_SHIFT : 0);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= COSC_OFF;
      wait_r <= '0;
    end else begin
      unique case (state_r)
        COSC_OFF: begin
          wait_r <= '0;
          if (run) begin
            state_r <= COSC_WAITING;
          end
        end
        COSC_WAITING: begin
          if (!run) begin
            state_r <= COSC_OFF;
          end else if (wait_r >= target) begin
            state_r <= COSC_STABLE;
          end else if (xtal_edge) begin
            wait_r <= wait_r + TGT_W'(1);
          end
        end
        COSC_STABLE: begin
          if (!run) begin
            state_r <= COSC_OFF;
          end
        end
        default: begin
          state_r <= COSC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stable_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      stable_r <= (state_r == COSC_STABLE) && run;
      run_r <= run;
    end
  end

  // ==================================================================
  // Interrupt status and mask.
  logic [`COSC_IRQ_W-1:0] irq_set;
  logic stable_rise;

  assign stable_rise = (state_r == COSC_STABLE) && run && !stable_r;
  always_comb begin
    irq_set = '0;
    irq_set[`COSC_IRQ_STABLE] = stable_rise;
    irq_set[`COSC_IRQ_CNT_ZERO] = count_zero_evt;
    irq_set[`COSC_IRQ_ILLEGAL] = illegal_evt;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= '0;
    end else if (rd_commit && (i_paddr == `COSC_OFS_IRQ_STAT)) begin
      // Only the bits returned by this read are cleared, so an event after capture is kept.
      irq_stat_r <= (irq_stat_r & ~prdata_r[`COSC_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_r <= '0;
    end else if (is_wr(wr_commit, i_paddr, `COSC_OFS_IRQ_MASK)) begin
      irq_mask_r <= i_pwdata[`COSC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ==================================================================
  // Read mux and APB response.
  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    unique case (i_paddr)
      `COSC_OFS_CTRL: begin
        rdata[`COSC_EN_MSB:`COSC_EN_LSB] = en_code_r;
        rdata[`COSC_RNG_MSB:`COSC_RNG_LSB] = `COSC_RNG_FIXED;
      end
      `COSC_OFS_STATE: begin
        rdata[`COSC_BIT_STABLE] = stable_r;
        rdata[`COSC_BIT_ILLEGAL] = illegal_r;
        rdata[`COSC_BIT_ENABLED] = run_r;
        rdata[`COSC_RNG_RD_MSB:`COSC_RNG_RD_LSB] = `COSC_RANGE_READ;
      end
      `COSC_OFS_PAUSE: rdata = pause_r;
      `COSC_OFS_SETTLE: begin
        rdata[DELAY_W-1:0] = delay_r;
        rdata[`COSC_BIT_TIMES4] = times4_r;
      end
      `COSC_OFS_COUNT: rdata[COUNT_W-1:0] = count_r;
      `COSC_OFS_IRQ_STAT: rdata[`COSC_IRQ_W-1:0] = irq_stat_r;
      `COSC_OFS_IRQ_MASK: rdata[`COSC_IRQ_W-1:0] = irq_mask_r;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (access_go) begin
      pready_r <= 1'b1;
      prdata_r <= i_pwrite ? 32'h0000_0000 : rdata;
      pslverr_r <= !mapped;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ==================================================================
  // Outputs.
  assign o_pready = pready_r;
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r;
  assign o_osc_run = run_r;
  assign o_osc_stable = stable_r;
  assign o_irq = irq_r;

endmodule : cosc_top

`default_nettype wire

// File: verif/cosc_top_asserts.sv
// Concurrent checks on the ports of the oscillator status and control block.
// Assumes it is bound to cosc_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "cosc_cfg.svh"

module cosc_top_asserts #(
  parameter int DELAY_W = 14,
  parameter int COUNT_W = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Oscillator side and interrupt.
  input wire logic i_xtal_clk,
  input wire logic o_osc_run,
  input wire logic o_osc_stable,
  input wire logic o_irq
);
  // ==================================================================
  // Read qualifier.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic rd_ok;
  assign rd_ok = o_pready && i_psel && i_penable && !i_pwrite && !o_pslverr;

  // ==================================================================
  // Checks.
  chk_range_zero: assert property (rd_ok && i_paddr == 8'h04 |-> o_prdata[1:0] == 2'h0)
    else $error("Range readback is not zero.");
  chk_status_mirror: assert property (rd_ok && i_paddr == 8'h04 |->
    o_prdata[31] == $past(o_osc_stable) && o_prdata[12] == $past(o_osc_run))
    else $error("Status flags disagree with outputs.");
  chk_range_fixed: assert property (rd_ok && i_paddr == 8'h00 |-> o_prdata[11:0] == 12'hAA0)
    else $error("Range control field changed.");
  chk_pause_legal: assert property (rd_ok && i_paddr == 8'h08 |->
    o_prdata == 32'h636F6D61 || o_prdata == 32'h77616B65)
    else $error("Pause register holds an illegal code.");
  chk_count_width: assert property (rd_ok && i_paddr == 8'h1C |-> o_prdata[31:8] == 24'h0)
    else $error("Counter upper bits not zero.");
  chk_stable_off: assert property (!o_osc_run [*2] |-> !o_osc_stable)
    else $error("Stable while oscillator is off.");
  chk_stable_cause: assert property ($rose(o_osc_stable) |-> $past(o_osc_run) && o_osc_run)
    else $error("Stable rose without a running oscillator.");
  chk_wait_restart: assert property ($rose(o_osc_run) |=> !o_osc_stable)
    else $error("Stable without a fresh wait.");
endmodule : cosc_top_asserts
`default_nettype wire

// File: verif/crystal_osc_status_control_tb_top.sv
// Self-checking bench for cosc_top driven over APB.
// Assumes the bench is the only bus master and makes the crystal clock itself.
`timescale 1ns/10ps
`default_nettype none
`include "cosc_cfg.svh"

module crystal_osc_status_control_tb_top;
  import cosc_pkg::*;
  // ==================================================================
  // Signals.
  localparam int UNIT = 256 * 8;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_xtal_clk = 1'b0;
  logic [1:0] xdiv = 2'h0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_osc_run, o_osc_stable, o_irq;
  logic [31:0] rv;
  logic re;
  int n_fail = 0;
  int checked = 0;
  int n;

  cosc_top #(.DELAY_W(14), .COUNT_W(8)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_xtal_clk(i_xtal_clk), .o_osc_run(o_osc_run),
    .o_osc_stable(o_osc_stable), .o_irq(o_irq));

  // ==================================================================
  // Clocks: bus clock and a crystal of eight bus periods.
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    xdiv <= xdiv + 2'h1;
    if (xdiv == 2'h3) begin
      i_xtal_clk <= ~i_xtal_clk;
    end
  end

  // ==================================================================
  // Tasks.
  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rv = o_prdata;
    re = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask : rdc
  task automatic irqc(input logic e);
    @(posedge i_clk);
    chk({31'h0, o_irq}, {31'h0, e});
  endtask : irqc
  task automatic wstab(input int lo, input int hi);
    n = 0;
    while (o_osc_stable !== 1'b1 && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask : wstab

  // ==================================================================
  // Watchdog and tests.
  initial begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rdc(`COSC_OFS_STATE, 32'hFFFFFFFF, 32'h0);
    rdc(`COSC_OFS_PAUSE, 32'hFFFFFFFF, `COSC_PAUSE_WAKE);
    rdc(`COSC_OFS_COUNT, 32'hFFFFFFFF, 32'h0);
    rdc(`COSC_OFS_CTRL, 32'hFFF, {20'h0, `COSC_RNG_FIXED});
    chk({31'h0, o_osc_run}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, re}, 32'h1);
    chk(rv, 32'h0);
    apb(1'b1, `COSC_OFS_SETTLE, 32'h1);
    apb(1'b1, `COSC_OFS_CTRL, {8'h0, `COSC_EN_ENABLE, 12'hAA1});
    rdc(`COSC_OFS_STATE, 32'h81001003, 32'h00001000);
    wstab(UNIT - 32, UNIT + 24);
    rdc(`COSC_OFS_STATE, 32'h81001003, 32'h80001000);
    chk({31'h0, o_osc_run}, 32'h1);
    chk({31'h0, o_irq}, 32'h0);
    apb(1'b1, `COSC_OFS_CTRL, {8'h0, `COSC_EN_ENABLE, 12'h123});
    rdc(`COSC_OFS_CTRL, 32'hFFF, {20'h0, `COSC_RNG_FIXED});
    rdc(`COSC_OFS_STATE, 32'h01000000, 32'h01000000);
    apb(1'b1, `COSC_OFS_STATE, 32'h0);
    rdc(`COSC_OFS_STATE, 32'h01000000, 32'h0);
    apb(1'b1, `COSC_OFS_CTRL, {8'h0, `COSC_EN_DISABLE, `COSC_RNG_FIXED});
    rdc(`COSC_OFS_STATE, 32'h81001000, 32'h0);
    apb(1'b1, `COSC_OFS_SETTLE, 32'h00100001);
    apb(1'b1, `COSC_OFS_CTRL, {8'h0, 12'h123, `COSC_RNG_FIXED});
    rdc(`COSC_OFS_STATE, 32'h01001000, 32'h01001000);
    wstab(4 * UNIT - 32, 4 * UNIT + 24);
    apb(1'b1, `COSC_OFS_SETTLE, 32'h1);
    apb(1'b1, `COSC_OFS_STATE, 32'h0);
    apb(1'b1, `COSC_OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `COSC_OFS_PAUSE, `COSC_PAUSE_STOP);
    rdc(`COSC_OFS_STATE, 32'h81001000, 32'h0);
    rdc(`COSC_OFS_PAUSE, 32'hFFFFFFFF, `COSC_PAUSE_STOP);
    apb(1'b1, `COSC_OFS_PAUSE, 32'h12345678);
    rdc(`COSC_OFS_PAUSE, 32'hFFFFFFFF, `COSC_PAUSE_WAKE);
    rdc(`COSC_OFS_STATE, 32'h01000000, 32'h01000000);
    wstab(UNIT - 32, UNIT + 24);
    apb(1'b0, `COSC_OFS_IRQ_STAT, 32'h0);
    apb(1'b1, `COSC_OFS_IRQ_MASK, 32'h2);
    apb(1'b1, `COSC_OFS_COUNT, 32'h5);
    apb(1'b0, `COSC_OFS_COUNT, 32'h0);
    chk({31'h0, rv != 32'h0}, 32'h1);
    n = 1;
    while (rv !== 32'h0 && n < 40) begin
      apb(1'b0, `COSC_OFS_COUNT, 32'h0);
      n++;
    end
    chk({31'h0, n >= 8 && n <= 14}, 32'h1);
    irqc(1'b1);
    apb(1'b1, `COSC_OFS_IRQ_MASK, 32'h0);
    irqc(1'b0);
    apb(1'b1, `COSC_OFS_IRQ_MASK, 32'h2);
    irqc(1'b1);
    rdc(`COSC_OFS_IRQ_STAT, 32'h2, 32'h2);
    irqc(1'b0);
    rdc(`COSC_OFS_COUNT, 32'hFFFFFFFF, 32'h0);
    give_verdict();
  end
endmodule : crystal_osc_status_control_tb_top

bind cosc_top cosc_top_asserts #(.DELAY_W(DELAY_W), .COUNT_W(COUNT_W)) i_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_xtal_clk(i_xtal_clk), .o_osc_run(o_osc_run), .o_osc_stable(o_osc_stable), .o_irq(o_irq));
`default_nettype wire
